// ===== src/pifb_bank.sv
// Peripheral interrupt flag and enable register bank with AXI4-Lite access
`include "pifb_cfg.svh"

module pifb_bank
   import pifb_pkg::*;
#(
   parameter bit LARGE_PIN_VARIANT = 1'b1,
   parameter int TX_BUFS           = 3,
   parameter int RX_BUFS           = 2
) (
   // Clock and reset
   input  wire logic               I_CORE_CLK,
   input  wire logic               I_SYS_RST,
   // AXI4-Lite write address
   input  wire logic               I_AWVALID,
   input  wire logic [7:0]         I_AWADDR,
   output logic                    O_AWREADY,
   // AXI4-Lite write data
   input  wire logic               I_WVALID,
   input  wire logic [31:0]        I_WDATA,
   input  wire logic [3:0]         I_WSTRB,
   output logic                    O_WREADY,
   // AXI4-Lite write response
   output logic                    O_BVALID,
   output logic [1:0]              O_BRESP,
   input  wire logic               I_BREADY,
   // AXI4-Lite read address
   input  wire logic               I_ARVALID,
   input  wire logic [7:0]         I_ARADDR,
   output logic                    O_ARREADY,
   // AXI4-Lite read data
   output logic                    O_RVALID,
   output logic [31:0]             O_RDATA,
   output logic [1:0]              O_RRESP,
   input  wire logic               I_RREADY,
   // CAN controller event pulses
   input  wire logic               I_CAN_BAD_MSG,
   input  wire logic               I_CAN_WAKE,
   input  wire logic               I_CAN_FAULT,
   input  wire logic [TX_BUFS-1:0] I_TX_DONE,
   input  wire logic [RX_BUFS-1:0] I_RX_FULL,
   input  wire logic               I_FIFO_HIGH_MARK,
   // Flag levels of the other peripheral flag registers
   input  wire logic [7:0]         I_PERIPH_A_FLAGS,
   input  wire logic [7:0]         I_PERIPH_B_FLAGS,
   // Towards the processor interrupt logic
   output logic                    O_PERIPH_IRQ_REQ,
   output logic                    O_PRIORITY_LEVELS_ON
);

   // ----------------------------------------------------------------
   // Mode dependent masks
   // ----------------------------------------------------------------
   function automatic logic [7:0] mode_mask(input pifb_mode_e m);
      case (m)
         PIFB_MODE_LEGACY:   mode_mask = `PIFB_MASK_MODE0;
         PIFB_MODE_ENHANCED: mode_mask = `PIFB_MASK_MODE1;
         default:            mode_mask = `PIFB_MASK_MODE2;
      endcase
   endfunction

   // Offsets that hold a register; any other offset answers SLVERR
   function automatic logic reg_mapped(input logic [7:0] a);
      case (a)
         `PIFB_OFS_CAN_FLAGS, `PIFB_OFS_EN_A, `PIFB_OFS_EN_B,
         `PIFB_OFS_CAN_EN, `PIFB_OFS_CTRL, `PIFB_OFS_BUF_EN: reg_mapped = 1'b1;
         default:                                         reg_mapped = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]         can_irq_flags;
   logic [7:0]         periph_irq_enable_a;
   logic [7:0]         periph_irq_enable_b;
   logic [7:0]         can_irq_enable;
   pifb_mode_e         can_mode;
   logic               global_irq_on;
   logic               peripheral_irq_gate;
   logic               priority_levels_on;
   logic [TX_BUFS-1:0] per_tx_buffer_enables;
   logic [RX_BUFS-1:0] per_buffer_enables;
   logic [TX_BUFS-1:0] tx_pend;
   logic [RX_BUFS-1:0] rx_pend;
   logic               aw_hold;
   logic [7:0]         aw_addr;
   logic               w_hold;
   logic [7:0]         w_byte;
   logic               w_lane0;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   wire        wr_fire   = aw_hold && w_hold && !O_BVALID;
   wire        wr_lane   = wr_fire && w_lane0;
   wire        wr_flags  = wr_lane && (aw_addr == `PIFB_OFS_CAN_FLAGS);
   wire        wr_en_a   = wr_lane && (aw_addr == `PIFB_OFS_EN_A);
   wire        wr_en_b   = wr_lane && (aw_addr == `PIFB_OFS_EN_B);
   wire        wr_can_en = wr_lane && (aw_addr == `PIFB_OFS_CAN_EN);
   wire        wr_ctrl   = wr_lane && (aw_addr == `PIFB_OFS_CTRL);
   wire        wr_buf_en = wr_lane && (aw_addr == `PIFB_OFS_BUF_EN);
   wire        wr_mapped = reg_mapped(aw_addr);

   // ----------------------------------------------------------------
   // Flag set logic
   // ----------------------------------------------------------------
   wire        mode0    = (can_mode == PIFB_MODE_LEGACY);
   wire        mode2    = (can_mode == PIFB_MODE_FIFO);
   wire [7:0]  cur_mask = mode_mask(can_mode);
   wire [7:0]  can_events;

   assign can_events[7] = I_CAN_BAD_MSG;
   assign can_events[6] = I_CAN_WAKE;
   assign can_events[5] = I_CAN_FAULT;
   assign can_events[4] = mode0 ? I_TX_DONE[2] : |I_TX_DONE;
   assign can_events[3] = mode0 && I_TX_DONE[1];
   assign can_events[2] = mode0 && I_TX_DONE[0];
   assign can_events[1] = mode0 ? I_RX_FULL[1] : |I_RX_FULL;
   assign can_events[0] = mode0 ? I_RX_FULL[0] : (mode2 && I_FIFO_HIGH_MARK);

   // Set wins over a software clear in the same cycle; events ignore enables
   wire [7:0]  flag_base  = wr_flags ? w_byte : can_irq_flags;
   wire [7:0]  next_flags = (flag_base | can_events) & cur_mask;

   // ----------------------------------------------------------------
   // Per-buffer pending bits
   // ----------------------------------------------------------------
   // Per-buffer pending bits stand behind the summary flags in modes 1 and 2
   wire        clr_tx     = wr_flags && !w_byte[`PIFB_TX_DONE_BIT];
   wire        clr_rx     = wr_flags && !w_byte[`PIFB_RX_FULL_BIT];
   wire [TX_BUFS-1:0] next_tx_pend = mode0 ? '0 : ((clr_tx ? '0 : tx_pend) | I_TX_DONE);
   wire [RX_BUFS-1:0] next_rx_pend = mode0 ? '0 : ((clr_rx ? '0 : rx_pend) | I_RX_FULL);

   // ----------------------------------------------------------------
   // Enable register next values
   // ----------------------------------------------------------------
   wire [7:0]  en_b_mask   = LARGE_PIN_VARIANT ? `PIFB_MASK_EN_B_LARGE
                                               : `PIFB_MASK_EN_B_SMALL;
   // Reserved enables of the small variant (bits 6 and 0 of enable B) are forced to zero by en_b_mask; the parallel-port enable in A is not
   wire [7:0]  next_en_a   = wr_en_a ? w_byte : periph_irq_enable_a;
   wire [7:0]  next_en_b   = (wr_en_b ? w_byte : periph_irq_enable_b) & en_b_mask;
   wire [7:0]  next_can_en = (wr_can_en ? w_byte : can_irq_enable) & cur_mask;
   wire [1:0]  wr_mode_raw = w_byte[`PIFB_CTRL_MODE_LSB +: 2];
   // Mode 3 is undefined; it is kept as mode 2 so the masks stay defined
   wire [1:0]  next_mode   = (wr_mode_raw == 2'h3) ? 2'h2 : wr_mode_raw;

   // ----------------------------------------------------------------
   // Named fields of the CAN flag and enable registers
   // ----------------------------------------------------------------
   wire        can_bad_msg_flag    = can_irq_flags[7];
   wire        can_wake_flag       = can_irq_flags[6];
   wire        can_fault_flag      = can_irq_flags[5];
   wire        tx_buf2_done_flag   = can_irq_flags[`PIFB_TX_DONE_BIT];
   wire        tx_buf1_done_flag   = can_irq_flags[3];
   wire        tx_buf0_done_flag   = can_irq_flags[2];
   wire        rx_buf1_full_flag   = can_irq_flags[`PIFB_RX_FULL_BIT];
   wire        rx_buf0_full_flag   = can_irq_flags[0];
   wire        fifo_high_mark_flag = can_irq_flags[0];
   wire        can_bad_msg_en      = can_irq_enable[7];
   wire        can_wake_en         = can_irq_enable[6];
   wire        can_fault_en        = can_irq_enable[5];
   wire        tx_buf2_done_en     = can_irq_enable[`PIFB_TX_DONE_BIT];
   wire        tx_master_en        = can_irq_enable[`PIFB_TX_DONE_BIT];
   wire        tx_buf1_done_en     = can_irq_enable[3];
   wire        tx_buf0_done_en     = can_irq_enable[2];
   wire        rx_buf1_full_en     = can_irq_enable[`PIFB_RX_FULL_BIT];
   wire        rx_master_en        = can_irq_enable[`PIFB_RX_FULL_BIT];
   wire        rx_buf0_full_en     = can_irq_enable[0];
   wire        fifo_high_mark_en   = can_irq_enable[0];

   // ----------------------------------------------------------------
   // CAN request
   // ----------------------------------------------------------------
   wire        bad_msg_hit = can_bad_msg_flag && can_bad_msg_en;
   wire        wake_hit    = can_wake_flag && can_wake_en;
   wire        fault_hit   = can_fault_flag && can_fault_en;
   wire        tx2_hit     = tx_buf2_done_flag && tx_buf2_done_en;
   wire        tx1_hit     = tx_buf1_done_flag && tx_buf1_done_en;
   wire        tx0_hit     = tx_buf0_done_flag && tx_buf0_done_en;
   wire        rx1_hit     = rx_buf1_full_flag && rx_buf1_full_en;
   // Bit 0 is stored as zero in mode 1, so only modes 0 and 2 can raise it
   wire        low_hit     = mode0 ? (rx_buf0_full_flag && rx_buf0_full_en)
                                   : (fifo_high_mark_flag && fifo_high_mark_en);
   wire        tx_req      = tx_master_en && |(tx_pend & per_tx_buffer_enables);
   wire        rx_req      = rx_master_en && |(rx_pend & per_buffer_enables);
   wire        common_hit  = bad_msg_hit || wake_hit || fault_hit || low_hit;
   // Summary bits 4 and 1 serve polling; modes 1 and 2 request through the
   // masters over the per-buffer pending bits
   wire        can_req     = mode0 ? (common_hit || tx2_hit || tx1_hit || tx0_hit || rx1_hit)
                                   : (common_hit || tx_req || rx_req);

   // ----------------------------------------------------------------
   // Request combining
   // ----------------------------------------------------------------
   wire        any_req    = |(I_PERIPH_A_FLAGS & periph_irq_enable_a)
                         || |(I_PERIPH_B_FLAGS & periph_irq_enable_b)
                         || can_req;
   // With priorities on, the core applies its own per-level gates
   wire        next_irq   = priority_levels_on ? any_req
                          : (global_irq_on && peripheral_irq_gate && any_req);

   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   wire [7:0]  ctrl_byte = {priority_levels_on, peripheral_irq_gate, global_irq_on,
                            3'h0, can_mode};
   wire [7:0]  buf_byte  = {3'h0, per_buffer_enables, per_tx_buffer_enables};
   wire        rd_mapped = reg_mapped(I_ARADDR);
   logic [7:0] rd_byte;

   always_comb begin
      case (I_ARADDR)
         `PIFB_OFS_CAN_FLAGS: rd_byte = can_irq_flags;
         `PIFB_OFS_EN_A:      rd_byte = periph_irq_enable_a;
         `PIFB_OFS_EN_B:      rd_byte = periph_irq_enable_b;
         `PIFB_OFS_CAN_EN:    rd_byte = can_irq_enable;
         `PIFB_OFS_CTRL:      rd_byte = ctrl_byte;
         `PIFB_OFS_BUF_EN:    rd_byte = buf_byte;
         default:             rd_byte = `PIFB_RST_BYTE;
      endcase
   end

   // ----------------------------------------------------------------
   // AXI write channels: address and data taken in either order
   // ----------------------------------------------------------------
   // Ready stays low until the response is taken: one write in flight
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         aw_hold   <= 1'b0;
         aw_addr   <= 8'h00;
         O_AWREADY <= 1'b1;
      end else if (I_AWVALID && O_AWREADY) begin
         aw_hold   <= 1'b1;
         aw_addr   <= I_AWADDR;
         O_AWREADY <= 1'b0;
      end else if (O_BVALID && I_BREADY) begin
         aw_hold   <= 1'b0;
         O_AWREADY <= 1'b1;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         w_hold   <= 1'b0;
         w_byte   <= 8'h00;
         w_lane0  <= 1'b0;
         O_WREADY <= 1'b1;
      end else if (I_WVALID && O_WREADY) begin
         w_hold   <= 1'b1;
         w_byte   <= I_WDATA[7:0];
         w_lane0  <= I_WSTRB[0];
         O_WREADY <= 1'b0;
      end else if (O_BVALID && I_BREADY) begin
         w_hold   <= 1'b0;
         O_WREADY <= 1'b1;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_BVALID <= 1'b0;
         O_BRESP  <= `PIFB_RESP_OKAY;
      end else if (wr_fire) begin
         O_BVALID <= 1'b1;
         O_BRESP  <= wr_mapped ? `PIFB_RESP_OKAY : `PIFB_RESP_SLVERR;
      end else if (I_BREADY) begin
         O_BVALID <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // AXI read channels
   // ----------------------------------------------------------------
   // Data is captured at acceptance, so a later event cannot tear it
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_ARREADY <= 1'b1;
         O_RVALID  <= 1'b0;
         O_RDATA   <= 32'h0000_0000;
         O_RRESP   <= `PIFB_RESP_OKAY;
      end else if (I_ARVALID && O_ARREADY) begin
         O_ARREADY <= 1'b0;
         O_RVALID  <= 1'b1;
         O_RDATA   <= {24'h00_0000, rd_byte};
         O_RRESP   <= rd_mapped ? `PIFB_RESP_OKAY : `PIFB_RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
         O_ARREADY <= 1'b1;
         O_RVALID  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         can_irq_flags       <= `PIFB_RST_BYTE;
         periph_irq_enable_a <= `PIFB_RST_BYTE;
         periph_irq_enable_b <= `PIFB_RST_BYTE;
         can_irq_enable      <= `PIFB_RST_BYTE;
         tx_pend             <= '0;
         rx_pend             <= '0;
      end else begin
         can_irq_flags       <= next_flags;
         periph_irq_enable_a <= next_en_a;
         periph_irq_enable_b <= next_en_b;
         can_irq_enable      <= next_can_en;
         tx_pend             <= next_tx_pend;
         rx_pend             <= next_rx_pend;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         can_mode              <= PIFB_MODE_LEGACY;
         global_irq_on         <= 1'b0;
         peripheral_irq_gate   <= 1'b0;
         priority_levels_on    <= 1'b0;
      end else if (wr_ctrl) begin
         can_mode              <= pifb_mode_e'(next_mode);
         global_irq_on         <= w_byte[`PIFB_CTRL_GLOBAL_BIT];
         peripheral_irq_gate   <= w_byte[`PIFB_CTRL_GATE_BIT];
         priority_levels_on    <= w_byte[`PIFB_CTRL_PRIO_BIT];
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         per_tx_buffer_enables <= '0;
         per_buffer_enables    <= '0;
      end else if (wr_buf_en) begin
         per_tx_buffer_enables <= w_byte[`PIFB_BUF_TX_LSB +: TX_BUFS];
         per_buffer_enables    <= w_byte[`PIFB_BUF_RX_LSB +: RX_BUFS];
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_PERIPH_IRQ_REQ     <= 1'b0;
         O_PRIORITY_LEVELS_ON <= 1'b0;
      end else begin
         O_PERIPH_IRQ_REQ     <= next_irq;
         O_PRIORITY_LEVELS_ON <= priority_levels_on;
      end
   end

endmodule // pifb_bank

// ===== inc/pifb_cfg.svh
// Register map, field positions, reset values and bus codes of the interrupt flag/enable bank
`ifndef PIFB_CFG_SVH
`define PIFB_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PIFB_OFS_CAN_FLAGS    8'h00
`define PIFB_OFS_EN_A         8'h04
`define PIFB_OFS_EN_B         8'h08
`define PIFB_OFS_CAN_EN       8'h0C
`define PIFB_OFS_CTRL         8'h10
`define PIFB_OFS_BUF_EN       8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PIFB_CTRL_MODE_LSB    0
`define PIFB_CTRL_GLOBAL_BIT  5
`define PIFB_CTRL_GATE_BIT    6
`define PIFB_CTRL_PRIO_BIT    7
`define PIFB_TX_DONE_BIT      4
`define PIFB_RX_FULL_BIT      1
`define PIFB_BUF_TX_LSB       0
`define PIFB_BUF_RX_LSB       3

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define PIFB_RST_BYTE         8'h00
`define PIFB_MASK_MODE0       8'hFF
`define PIFB_MASK_MODE1       8'hF2
`define PIFB_MASK_MODE2       8'hF3
`define PIFB_MASK_EN_B_LARGE  8'hDF
`define PIFB_MASK_EN_B_SMALL  8'h9E

// ----------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------
`define PIFB_RESP_OKAY        2'h0
`define PIFB_RESP_SLVERR      2'h2

`endif

// ===== inc/pifb_pkg.sv
// Types shared by the interrupt flag/enable bank
package pifb_pkg;

   // CAN operating modes
   typedef enum logic [1:0] {
      PIFB_MODE_LEGACY   = 2'h0,
      PIFB_MODE_ENHANCED = 2'h1,
      PIFB_MODE_FIFO     = 2'h2
   } pifb_mode_e;

endpackage : pifb_pkg

// ===== testbench/pifb_bank_assertions.sv
// Bus-handshake and control-bit assertions for the interrupt flag/enable bank
module pifb_bank_assertions (
   // Clock and reset
   input wire logic        I_CORE_CLK,
   input wire logic        I_SYS_RST,
   // Write channels
   input wire logic        I_AWVALID,
   input wire logic        O_AWREADY,
   input wire logic        I_WVALID,
   input wire logic        O_WREADY,
   input wire logic        O_BVALID,
   input wire logic [1:0]  O_BRESP,
   input wire logic        I_BREADY,
   // Read channels
   input wire logic        I_ARVALID,
   input wire logic [7:0]  I_ARADDR,
   input wire logic        O_ARREADY,
   input wire logic        O_RVALID,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0]  O_RRESP,
   input wire logic        I_RREADY,
   // Priority mode
   input wire logic        O_PRIORITY_LEVELS_ON
);
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);

   property p_aw_block;
      (I_AWVALID && O_AWREADY) |=> !O_AWREADY;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write accepted while one pending");
   property p_b_lat;
      (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY) |-> ##1 !O_BVALID ##1 O_BVALID;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write response latency wrong");
   property p_b_hold;
      (O_BVALID && !I_BREADY) |=> O_BVALID && $stable(O_BRESP);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_lat;
      (I_ARVALID && O_ARREADY) |=> O_RVALID && !O_ARREADY;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read data not one cycle after address");
   property p_r_hold;
      (O_RVALID && !I_RREADY) |=> O_RVALID && $stable(O_RDATA);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data changed before taken");
   property p_r_upper;
      O_RVALID |-> O_RDATA[31:8] == 24'h0;
   endproperty
   a_r_upper: assert property (p_r_upper) else $error("upper read bits not zero");
   property p_slverr;
      (I_ARVALID && O_ARREADY && I_ARADDR > 8'h14) |=> O_RRESP == 2'h2 && O_RDATA == 32'h0;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
   property p_prio;
      $changed(O_PRIORITY_LEVELS_ON) |-> $past(O_BVALID) && !$past(O_BVALID, 2);
   endproperty
   a_prio: assert property (p_prio) else $error("priority mode changed without a write");

   c_write: cover property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY);
   c_read: cover property (O_RVALID && I_RREADY);
   c_prio: cover property ($rose(O_PRIORITY_LEVELS_ON));
endmodule // pifb_bank_assertions

bind pifb_bank pifb_bank_assertions u_chk (
   .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_AWVALID(I_AWVALID),
   .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
   .O_BRESP(O_BRESP), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .I_ARADDR(I_ARADDR),
   .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
   .I_RREADY(I_RREADY), .O_PRIORITY_LEVELS_ON(O_PRIORITY_LEVELS_ON)
);

// ===== testbench/pifb_src_model.sv
// Behavioural model of the peripheral event sources feeding the bank
module pifb_src_model (
   input  wire logic clk,
   output logic       bad_msg,
   output logic       wake,
   output logic       fault,
   output logic [2:0] tx_done,
   output logic [1:0] rx_full,
   output logic       fifo_mark,
   output logic [7:0] flags_a,
   output logic [7:0] flags_b
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {fifo_mark, rx_full, tx_done, fault, wake, bad_msg} = 9'h000;
      flags_a = 8'h00;
      flags_b = 8'h00;
   end
   // One-cycle event pulses, as the controller emits them
   task automatic pulse(input logic [8:0] v);
      @(posedge clk);
      {fifo_mark, rx_full, tx_done, fault, wake, bad_msg} <= v;
      @(posedge clk);
      {fifo_mark, rx_full, tx_done, fault, wake, bad_msg} <= 9'h000;
   endtask
   // Levels of the flag registers kept elsewhere
   task automatic levels(input logic [7:0] a, input logic [7:0] b);
      @(posedge clk);
      flags_a <= a;
      flags_b <= b;
   endtask
endmodule // pifb_src_model

// ===== testbench/tb_peripheral_irq_flag_enable_bank.sv
// Register-level testbench of the interrupt flag/enable bank
module tb_peripheral_irq_flag_enable_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic        awrdy, wrdy, bv, arrdy, rv, req, prio, bad, wk, flt, fifo;
   logic [1:0]  bresp, rresp, rxf;
   logic [2:0]  txd;
   logic [31:0] rdata;
   logic [7:0]  fa, fb;
   logic [3:0]  ws = 4'hF;
   int          n_mismatch = 0, tests_run = 0;
   logic [7:0]  map [0:7] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h08, 8'h10, 8'h01, 8'h02};

   always #5 clk = ~clk;

   pifb_src_model src (.clk(clk), .bad_msg(bad), .wake(wk), .fault(flt), .tx_done(txd),
      .rx_full(rxf), .fifo_mark(fifo), .flags_a(fa), .flags_b(fb));

   pifb_bank dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_AWVALID(awv), .I_AWADDR(awa),
      .O_AWREADY(awrdy), .I_WVALID(wv), .I_WDATA(wd), .I_WSTRB(ws), .O_WREADY(wrdy),
      .O_BVALID(bv), .O_BRESP(bresp), .I_BREADY(brdy), .I_ARVALID(arv), .I_ARADDR(ara),
      .O_ARREADY(arrdy), .O_RVALID(rv), .O_RDATA(rdata), .O_RRESP(rresp), .I_RREADY(rrdy),
      .I_CAN_BAD_MSG(bad), .I_CAN_WAKE(wk), .I_CAN_FAULT(flt), .I_TX_DONE(txd),
      .I_RX_FULL(rxf), .I_FIFO_HIGH_MARK(fifo), .I_PERIPH_A_FLAGS(fa),
      .I_PERIPH_B_FLAGS(fb), .O_PERIPH_IRQ_REQ(req), .O_PRIORITY_LEVELS_ON(prio));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Write one register; address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic done;
      done = 0;
      @(posedge clk);
      awv <= 1; awa <= a; wv <= 1; wd <= {24'h0, d}; brdy <= 1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge clk);
         if (awv && awrdy) awv <= 0;
         if (wv && wrdy) wv <= 0;
         if (bv && brdy) begin
            done = 1;
            brdy <= 0;
            chk("bresp", 32'(er), 32'(bresp));
         end
      end
      if (!done) chk("bwait", 32'h1, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      logic done;
      done = 0;
      @(posedge clk);
      arv <= 1; ara <= a; rrdy <= 1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge clk);
         if (arv && arrdy) arv <= 0;
         if (rv && rrdy) begin
            done = 1;
            rrdy <= 0;
            chk("rdata", {24'h0, ed}, rdata);
            chk("rresp", 32'(er), 32'(rresp));
         end
      end
      if (!done) chk("rwait", 32'h1, 32'h0);
   endtask

   // Request settles within two edges of its cause
   task automatic chk_req(input logic e);
      repeat (2) @(posedge clk);
      #1;
      chk("irq_req", 32'(e), 32'(req));
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      results();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      // --------------------------------------------------------------
      // Reset values, masks of the enable registers
      // --------------------------------------------------------------
      for (int i = 0; i < 6; i++) rd(8'(4 * i), 8'h00, 2'h0);
      // Large variant: the parallel port enable may be set
      wr(8'h04, 8'hFF, 2'h0);
      rd(8'h04, 8'hFF, 2'h0);
      // Lane 0 not strobed: the write is answered but stores nothing
      ws <= 4'h0;
      wr(8'h04, 8'h00, 2'h0);
      ws <= 4'hF;
      rd(8'h04, 8'hFF, 2'h0);
      wr(8'h08, 8'hFF, 2'h0);
      rd(8'h08, 8'hDF, 2'h0);
      // --------------------------------------------------------------
      // Mode 0: each event sets its own flag with all CAN enables off
      // --------------------------------------------------------------
      for (int i = 0; i < 8; i++) begin
         wr(8'h00, 8'h00, 2'h0);
         src.pulse(9'(1 << i));
         rd(8'h00, map[i], 2'h0);
      end
      wr(8'h0C, 8'hFF, 2'h0);
      rd(8'h0C, 8'hFF, 2'h0);
      // --------------------------------------------------------------
      // Modes 1 and 2: shared bits and forced zeros
      // --------------------------------------------------------------
      wr(8'h10, 8'h01, 2'h0);
      rd(8'h0C, 8'hF2, 2'h0);
      wr(8'h00, 8'h00, 2'h0);
      src.pulse(9'h010);
      rd(8'h00, 8'h10, 2'h0);
      wr(8'h00, 8'h00, 2'h0);
      src.pulse(9'h040);
      rd(8'h00, 8'h02, 2'h0);
      wr(8'h00, 8'h00, 2'h0);
      src.pulse(9'h100);
      rd(8'h00, 8'h00, 2'h0);
      wr(8'h10, 8'h02, 2'h0);
      rd(8'h0C, 8'hF2, 2'h0);
      wr(8'h0C, 8'hFF, 2'h0);
      rd(8'h0C, 8'hF3, 2'h0);
      src.pulse(9'h100);
      rd(8'h00, 8'h01, 2'h0);
      // --------------------------------------------------------------
      // Request gating by global, peripheral gate and priority mode
      // --------------------------------------------------------------
      wr(8'h0C, 8'h00, 2'h0);
      wr(8'h00, 8'h00, 2'h0);
      wr(8'h10, 8'h20, 2'h0);
      src.levels(8'h40, 8'h00);
      chk_req(1'b0);
      wr(8'h10, 8'h60, 2'h0);
      chk_req(1'b1);
      wr(8'h10, 8'h80, 2'h0);
      chk_req(1'b1);
      chk("prio", 32'h1, 32'(prio));
      src.levels(8'h00, 8'h00);
      // --------------------------------------------------------------
      // Mode 1 transmit master enable over per-buffer enables
      // --------------------------------------------------------------
      wr(8'h10, 8'h61, 2'h0);
      #1;
      chk("prio", 32'h0, 32'(prio));
      wr(8'h14, 8'h02, 2'h0);
      wr(8'h0C, 8'h10, 2'h0);
      wr(8'h00, 8'h00, 2'h0);
      chk_req(1'b0);
      src.pulse(9'h010);
      chk_req(1'b1);
      wr(8'h0C, 8'h00, 2'h0);
      chk_req(1'b0);
      // --------------------------------------------------------------
      // Unmapped place is refused on both paths
      // --------------------------------------------------------------
      rd(8'h18, 8'h00, 2'h2);
      wr(8'h18, 8'h55, 2'h2);
      results();
   end
endmodule // tb_peripheral_irq_flag_enable_bank
